// ### core/rail_enable_sequencing.v
/*
 * Enable sequencing for step-down rails e and f: programmable edge delays on
 * rail e's enable, pin/power-good enable condition and step size for rail f.
 * Assumes all inputs are synchronous to i_clk and that the register port is
 * driven by the device's host interface, one access per cycle.
 */
`include "rail_seq_defines.vh"
`default_nettype none

module rail_enable_sequencing #(
    parameter MS_CYCLES = `MS_CYCLES
) (
    input  wire       i_clk,                      // 25 MHz clock
    input  wire       i_rst_n,                    // asynchronous reset, active low
    input  wire [7:0] i_reg_addr,                 // register offset
    input  wire [7:0] i_reg_wdata,                // write data
    input  wire       i_reg_wr_en,                // write strobe
    input  wire       i_reg_rd_en,                // read strobe
    output reg  [7:0] o_reg_rdata,                // read data, valid the cycle after read
    input  wire       i_rail_e_enable_cond,       // rail e enable before delays
    input  wire [6:1] i_ctrl_input,               // control input pins 1 to 6
    input  wire [7:0] i_power_good_rails,         // power good, bit order as masks
    input  wire       i_power_good_shared_switch, // shared switch/linear rail power good
    input  wire       i_power_good_switch_b,      // load switch b power good
    output wire       o_rail_e_enable,            // rail e enable after delays
    output reg        o_rail_f_enable,            // rail f enable condition
    output wire       o_rail_f_voltage_increment  // 1: 25 mV steps, 0: 10 mV steps
);

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg [7:0] rail_e_enable_edge_delays_q;
    reg [7:0] rail_f_power_good_masks_q;
    reg [7:0] rail_f_pin_select_and_step_q;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rail_e_enable_edge_delays_q  <= `RST_RAIL_E_EDGE_DELAYS;
            rail_f_power_good_masks_q    <= `RST_RAIL_F_PG_MASKS;
            rail_f_pin_select_and_step_q <= `RST_RAIL_F_PIN_SEL_STEP;
        end else if (i_reg_wr_en) begin
            case (i_reg_addr)
                `ADDR_RAIL_E_EDGE_DELAYS:  rail_e_enable_edge_delays_q  <= i_reg_wdata;
                `ADDR_RAIL_F_PG_MASKS:     rail_f_power_good_masks_q    <= i_reg_wdata;
                `ADDR_RAIL_F_PIN_SEL_STEP: rail_f_pin_select_and_step_q <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    // Unmapped offsets read as zero.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd_en) begin
            case (i_reg_addr)
                `ADDR_RAIL_E_EDGE_DELAYS:  o_reg_rdata <= rail_e_enable_edge_delays_q;
                `ADDR_RAIL_F_PG_MASKS:     o_reg_rdata <= rail_f_power_good_masks_q;
                `ADDR_RAIL_F_PIN_SEL_STEP: o_reg_rdata <= rail_f_pin_select_and_step_q;
                default:                   o_reg_rdata <= 8'h00;
            endcase
        end
    end

    wire [2:0] rail_e_fall_delay_sel = rail_e_enable_edge_delays_q[`FALL_DLY_MSB:`FALL_DLY_LSB];
    wire [2:0] rail_e_rise_delay_sel = rail_e_enable_edge_delays_q[`RISE_DLY_MSB:`RISE_DLY_LSB];
    wire [2:0] rail_f_enable_source_sel =
        rail_f_pin_select_and_step_q[`PIN_SEL_MSB:`PIN_SEL_LSB];
    wire       rail_f_mask_shared_switch =
        rail_f_pin_select_and_step_q[`MASK_SHARED_SWITCH_BIT];
    wire       rail_f_mask_switch_b = rail_f_pin_select_and_step_q[`MASK_SWITCH_B_BIT];

    // Only the setting is held here; the regulator's reference applies it.
    assign o_rail_f_voltage_increment = rail_f_pin_select_and_step_q[`STEP_SIZE_BIT];

    // ****************************************************************
    // Rail f enable condition
    // ****************************************************************
    function pin_term;
        input [2:0] sel;
        input [6:1] pins;
        begin
            case (sel)
                `PIN_SEL_CTRL1:       pin_term = pins[1];
                `PIN_SEL_CTRL2:       pin_term = pins[2];
                `PIN_SEL_CTRL5:       pin_term = pins[5];
                `PIN_SEL_CTRL4:       pin_term = pins[4];
                `PIN_SEL_CTRL3:       pin_term = pins[3];
                `PIN_SEL_CTRL3_AND_4: pin_term = pins[3] & pins[4];
                `PIN_SEL_CTRL6:       pin_term = pins[6];
                default:              pin_term = 1'b1;
            endcase
        end
    endfunction

    // A set mask bit forces its term true, removing that rail from the AND.
    wire rails_good = &(i_power_good_rails | rail_f_power_good_masks_q);
    wire switches_good = (i_power_good_shared_switch | rail_f_mask_shared_switch) &
                         (i_power_good_switch_b | rail_f_mask_switch_b);

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rail_f_enable <= 1'b0;
        end else begin
            o_rail_f_enable <= pin_term(rail_f_enable_source_sel, i_ctrl_input) &
                               rails_good & switches_good;
        end
    end

    // ****************************************************************
    // Rail e edge delays
    // ****************************************************************
    function [6:0] delay_ms;
        input [2:0] code;
        begin
            case (code)
                `DLY_CODE_0: delay_ms = `DLY_MS_0;
                `DLY_CODE_1: delay_ms = `DLY_MS_1;
                `DLY_CODE_2: delay_ms = `DLY_MS_2;
                `DLY_CODE_3: delay_ms = `DLY_MS_3;
                `DLY_CODE_4: delay_ms = `DLY_MS_4;
                `DLY_CODE_5: delay_ms = `DLY_MS_5;
                `DLY_CODE_6: delay_ms = `DLY_MS_6;
                default:     delay_ms = `DLY_MS_7;
            endcase
        end
    endfunction

    localparam [3:0] ST_OFF       = 4'b0001;
    localparam [3:0] ST_RISE_WAIT = 4'b0010;
    localparam [3:0] ST_ON        = 4'b0100;
    localparam [3:0] ST_FALL_WAIT = 4'b1000;
    localparam [31:0] MS_LAST = MS_CYCLES - 1;

    reg  [3:0]  state_q;
    reg  [3:0]  state_d;
    reg  [31:0] prescale_q;
    reg  [6:0]  ms_count_q;
    wire        waiting  = (state_q == ST_RISE_WAIT) || (state_q == ST_FALL_WAIT);
    wire        ms_tick  = waiting && (prescale_q == MS_LAST);
    // The prescaler restarts at each wait, so a delay is whole milliseconds,
    // not up to one short as a free-running tick would make it.
    wire [6:0]  target   = (state_q == ST_RISE_WAIT) ? delay_ms(rail_e_rise_delay_sel)
                                                     : delay_ms(rail_e_fall_delay_sel);
    wire        expired  = ms_tick && ((ms_count_q + 7'h01) >= target);

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (i_rail_e_enable_cond) begin
                    state_d = (delay_ms(rail_e_rise_delay_sel) == `DLY_MS_0) ? ST_ON
                                                                            : ST_RISE_WAIT;
                end
            end
            ST_RISE_WAIT: begin
                if (!i_rail_e_enable_cond) begin
                    state_d = ST_OFF;
                end else if (expired) begin
                    state_d = ST_ON;
                end
            end
            ST_ON: begin
                if (!i_rail_e_enable_cond) begin
                    state_d = (delay_ms(rail_e_fall_delay_sel) == `DLY_MS_0) ? ST_OFF
                                                                            : ST_FALL_WAIT;
                end
            end
            ST_FALL_WAIT: begin
                if (i_rail_e_enable_cond) begin
                    state_d = ST_ON;
                end else if (expired) begin
                    state_d = ST_OFF;
                end
            end
            default: state_d = ST_OFF;
        endcase
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q    <= ST_OFF;
            prescale_q <= 32'h0;
            ms_count_q <= 7'h00;
        end else begin
            state_q <= state_d;
            if (!waiting || (state_d != state_q)) begin
                prescale_q <= 32'h0;
                ms_count_q <= 7'h00;
            end else if (ms_tick) begin
                prescale_q <= 32'h0;
                ms_count_q <= ms_count_q + 7'h01;
            end else begin
                prescale_q <= prescale_q + 32'h1;
            end
        end
    end

    // The enable drives a regulator, so it comes from a flop rather than a
    // state decode that could glitch while two state bits change together.
    reg         rail_e_enable_q;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rail_e_enable_q <= 1'b0;
        end else begin
            rail_e_enable_q <= (state_d == ST_ON) || (state_d == ST_FALL_WAIT);
        end
    end

    assign o_rail_e_enable = rail_e_enable_q;

endmodule

`default_nettype wire

// ### common/rail_seq_defines.vh
/*
 * Register offsets, field positions, reset values and timing constants for the
 * rail enable sequencing block.
 * Assumes inclusion by bare name from the design file; definitions only.
 */
`ifndef RAIL_SEQ_DEFINES_VH
`define RAIL_SEQ_DEFINES_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADDR_RAIL_E_EDGE_DELAYS    8'h15
`define ADDR_RAIL_F_PG_MASKS       8'h16
`define ADDR_RAIL_F_PIN_SEL_STEP   8'h17

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_RAIL_E_EDGE_DELAYS     8'h00
`define RST_RAIL_F_PG_MASKS        8'h00
`define RST_RAIL_F_PIN_SEL_STEP    8'hc0

// ****************************************************************
// Field positions
// ****************************************************************
`define FALL_DLY_MSB               5
`define FALL_DLY_LSB               3
`define RISE_DLY_MSB               2
`define RISE_DLY_LSB               0
`define STEP_SIZE_BIT              5
`define PIN_SEL_MSB                4
`define PIN_SEL_LSB                2
`define MASK_SHARED_SWITCH_BIT     1
`define MASK_SWITCH_B_BIT          0

// ****************************************************************
// Enable pin select codes
// ****************************************************************
`define PIN_SEL_CTRL1              3'h0
`define PIN_SEL_CTRL2              3'h1
`define PIN_SEL_CTRL5              3'h2
`define PIN_SEL_CTRL4              3'h3
`define PIN_SEL_CTRL3              3'h4
`define PIN_SEL_CTRL3_AND_4        3'h5
`define PIN_SEL_CTRL6              3'h6
`define PIN_SEL_FORCED_ON          3'h7

// ****************************************************************
// Edge delay codes and their times in milliseconds
// ****************************************************************
`define DLY_CODE_0                 3'h0
`define DLY_CODE_1                 3'h1
`define DLY_CODE_2                 3'h2
`define DLY_CODE_3                 3'h3
`define DLY_CODE_4                 3'h4
`define DLY_CODE_5                 3'h5
`define DLY_CODE_6                 3'h6
`define DLY_MS_0                   7'h00
`define DLY_MS_1                   7'h02
`define DLY_MS_2                   7'h04
`define DLY_MS_3                   7'h08
`define DLY_MS_4                   7'h10
`define DLY_MS_5                   7'h18
`define DLY_MS_6                   7'h20
`define DLY_MS_7                   7'h40

// ****************************************************************
// Time base
// ****************************************************************
`define CLK_FREQ_KHZ               25000
`define MS_PER_TICK                1
`define MS_CYCLES                  (`CLK_FREQ_KHZ * `MS_PER_TICK)

`endif

// ### verification/ctrl_pin_host.sv
/* Host model driving the six control input pins of the device.
   Assumes the bench chooses the levels; the host passes them on unchanged. */
`default_nettype none
module ctrl_pin_host (
    input  wire logic [6:1] i_pins,      // levels the host wants
    output logic      [6:1] o_ctrl_input // pins seen by the device
);
    timeunit 1ns;
    timeprecision 1ps;
    assign o_ctrl_input = i_pins;
endmodule
`default_nettype wire

// ### verification/rail_seq_monitor.sv
/* Port checker for the rail enable sequencing block, bound into the design.
   Assumes registers change only through the register port of the block. */
`default_nettype none
module rail_seq_monitor #(parameter int MS_CYCLES = 4) (
    input wire logic       i_clk,                      // clock
    input wire logic       i_rst_n,                    // reset, active low
    input wire logic [7:0] i_reg_addr,                 // offset
    input wire logic [7:0] i_reg_wdata,                // write data
    input wire logic       i_reg_wr_en,                // write strobe
    input wire logic       i_reg_rd_en,                // read strobe
    input wire logic [7:0] o_reg_rdata,                // read data
    input wire logic       i_rail_e_enable_cond,       // rail e request
    input wire logic [6:1] i_ctrl_input,               // pins
    input wire logic [7:0] i_power_good_rails,         // power good
    input wire logic       i_power_good_shared_switch, // power good
    input wire logic       i_power_good_switch_b,      // power good
    input wire logic       o_rail_e_enable,            // rail e enable
    input wire logic       o_rail_f_enable,            // rail f enable
    input wire logic       o_rail_f_voltage_increment  // step size
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS_TAB [8] = '{0, 2, 4, 8, 16, 24, 32, 64};
    localparam int PIN_OF [8] = '{1, 2, 5, 4, 3, 3, 6, 1};
    logic [7:0]  e_q, m_q, s_q, rd_v;
    logic [31:0] run_q;
    logic        cond_q, pin, pg_ok, f_exp;
    // ****************************************************************
    // Register mirror and settle counter
    // ****************************************************************
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            e_q <= 8'h00;
            m_q <= 8'h00;
            s_q <= 8'hc0;
            cond_q <= 1'b0;
            run_q <= 32'h0;
        end else begin
            if (i_reg_wr_en && i_reg_addr == 8'h15) e_q <= i_reg_wdata;
            if (i_reg_wr_en && i_reg_addr == 8'h16) m_q <= i_reg_wdata;
            if (i_reg_wr_en && i_reg_addr == 8'h17) s_q <= i_reg_wdata;
            cond_q <= i_rail_e_enable_cond;
            run_q <= (i_rail_e_enable_cond != cond_q) ? 32'h0 : run_q + {31'h0, ~&run_q};
        end
    end
    always_comb begin
        pin = (s_q[4:2] == 3'h7) | (s_q[4:2] == 3'h5 ? i_ctrl_input[3] & i_ctrl_input[4]
              : i_ctrl_input[PIN_OF[s_q[4:2]]]);
        pg_ok = &(i_power_good_rails | m_q) & (i_power_good_shared_switch | s_q[1])
                & (i_power_good_switch_b | s_q[0]);
        f_exp = pin & pg_ok;
        rd_v = i_reg_addr == 8'h15 ? e_q : i_reg_addr == 8'h16 ? m_q
             : i_reg_addr == 8'h17 ? s_q : 8'h00;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_f_enable_calc: assert property (
        1'b1 |=> o_rail_f_enable == $past(f_exp)) else $error("rail f enable wrong");
    a_f_forced_on: assert property (
        s_q[4:2] == 3'h7 && pg_ok |=> o_rail_f_enable) else $error("forced rail f off");
    a_f_mask_rails: assert property (
        (~i_power_good_rails & ~m_q) != 8'h00 |=> !o_rail_f_enable) else $error("rail mask");
    a_f_mask_switches: assert property (
        !(i_power_good_shared_switch | s_q[1]) || !(i_power_good_switch_b | s_q[0])
        |=> !o_rail_f_enable) else $error("switch mask ignored");
    a_step_size: assert property (
        o_rail_f_voltage_increment == s_q[5]) else $error("step size wrong");
    a_read_back: assert property (
        i_reg_rd_en |=> o_reg_rdata == $past(rd_v)) else $error("read data wrong");
    a_read_hold: assert property (
        !i_reg_rd_en |=> $stable(o_reg_rdata)) else $error("read data moved");
    a_e_rise_time: assert property (
        $rose(o_rail_e_enable) |-> cond_q && run_q == MS_TAB[e_q[2:0]] * MS_CYCLES)
        else $error("rail e rose at wrong time");
    a_e_fall_time: assert property (
        $fell(o_rail_e_enable) |-> !cond_q && run_q == MS_TAB[e_q[5:3]] * MS_CYCLES)
        else $error("rail e fell at wrong time");
    a_e_not_late: assert property (
        i_rail_e_enable_cond == cond_q && run_q == MS_TAB[cond_q ? e_q[2:0] : e_q[5:3]]
        * MS_CYCLES |-> o_rail_e_enable == cond_q) else $error("rail e late");
    c_forced_on: cover property (s_q[4:2] == 3'h7 ##1 o_rail_f_enable);
    c_rail_e_rise: cover property ($rose(o_rail_e_enable));
    c_cond_glitch: cover property ($rose(i_rail_e_enable_cond) ##3 $fell(i_rail_e_enable_cond));
endmodule
bind rail_enable_sequencing rail_seq_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr_en(i_reg_wr_en), .i_reg_rd_en(i_reg_rd_en), .o_reg_rdata(o_reg_rdata),
    .i_rail_e_enable_cond(i_rail_e_enable_cond), .i_ctrl_input(i_ctrl_input),
    .i_power_good_rails(i_power_good_rails), .o_rail_e_enable(o_rail_e_enable),
    .i_power_good_shared_switch(i_power_good_shared_switch), .o_rail_f_enable(o_rail_f_enable),
    .i_power_good_switch_b(i_power_good_switch_b),
    .o_rail_f_voltage_increment(o_rail_f_voltage_increment));
`default_nettype wire

// ### verification/rail_enable_sequencing_test.sv
/* Self-checking bench for rail_enable_sequencing with a pin host model.
   Assumes the design header is on the include path; a short millisecond is used. */
`default_nettype none
module rail_enable_sequencing_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 2;
    localparam int PIN_OF [8] = '{1, 2, 5, 4, 3, 3, 6, 1};
    localparam int MS_TAB [8] = '{0, 2, 4, 8, 16, 24, 32, 64};
    typedef struct packed {logic [1:0] what; logic [15:0] val;} note_t;
    note_t       notes [$];
    note_t       n;
    logic        clk = '0, rst_n = '0, wr = '0, rd = '0, probe = '0, cond = '0, cprev = '0;
    logic        rd_s = '0, pr_s = '0, pg_sh = '0, pg_b = '0, oe_prev = '0, rail_e, rail_f, incr;
    logic [7:0]  addr = '0, wdata = '0, pg = '0, d, rdata;
    logic [7:0]  cfg [3] = '{8'h00, 8'h00, 8'hc0};
    logic [6:1]  pins = '0, ctrl;
    logic [15:0] got, lat = '0, r;
    string       nm [4] = '{"rdata", "rail_f_enable", "voltage_increment", "rail_e_latency"};
    int          miscompares = 0, n_compared = 0, cycles = 0, seed = 32'hc19a, k;
    rail_enable_sequencing #(.MS_CYCLES(MS)) dut (
        .i_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr_en(wr), .i_reg_rd_en(rd), .o_reg_rdata(rdata), .i_rail_e_enable_cond(cond),
        .i_ctrl_input(ctrl), .i_power_good_rails(pg), .i_power_good_shared_switch(pg_sh),
        .i_power_good_switch_b(pg_b), .o_rail_e_enable(rail_e), .o_rail_f_enable(rail_f),
        .o_rail_f_voltage_increment(incr));
    ctrl_pin_host host (.i_pins(pins), .o_ctrl_input(ctrl));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic final_report();
        if (notes.size() != 0) miscompares++;
        if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cyc(input logic w, rq, p, input logic [7:0] a, wd, input logic [1:0] wh,
                       input logic [15:0] v);
        addr = a;
        wdata = wd;
        wr = w;
        rd = rq;
        probe = p;
        if (rq | p) notes.push_back({wh, v});
        @(negedge clk);
    endtask
    task automatic wreg(input logic [7:0] a, wd);
        if (a > 8'h14 && a < 8'h18) cfg[a - 8'h15] = wd;
        cyc(1, 0, 0, a, wd, 0, 0);
    endtask
    task automatic rreg(input logic [7:0] a);
        cyc(0, 1, 0, a, 8'h00, 0, {8'h00, (a > 8'h14 && a < 8'h18) ? cfg[a - 8'h15] : 8'h00});
    endtask
    task automatic wait_e(input logic v);
        for (int i = 0; i < 300 && rail_e !== v; i++) @(negedge clk);
        @(negedge clk);
    endtask
    function automatic logic f_exp();
        logic [2:0] s;
        s = cfg[2][4:2];
        f_exp = (s == 3'h7 ? 1'b1 : s == 3'h5 ? pins[3] & pins[4] : pins[PIN_OF[s]])
                & (&(pg | cfg[1])) & (pg_sh | cfg[2][1]) & (pg_b | cfg[2][0]);
    endfunction
    // ****************************************************************
    // Scoreboard: one note is taken per result that shows at the ports
    // ****************************************************************
    always @(posedge clk) begin
        rd_s <= rd;
        pr_s <= probe;
        lat <= (cond != cprev) ? 16'h0000 : lat + 16'h0001;
        cprev <= cond;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            final_report();
        end
    end
    always @(negedge clk) begin
        if (rd_s | pr_s | (rail_e !== oe_prev)) begin
            n = notes.size() ? notes.pop_front() : '1;
            case (n.what)
                2'd0: got = {8'h00, rdata};
                2'd1: got = {15'h0, rail_f};
                2'd2: got = {15'h0, incr};
                default: got = lat;
            endcase
            n_compared++;
            if (got !== n.val) begin
                miscompares++;
                $display("mismatch %s expected %h seen %h", nm[n.what], n.val, got);
            end
        end
        oe_prev = rail_e;
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        for (k = 0; k < 5; k++) rreg(8'h14 + 8'(k));
        cyc(0, 0, 1, 8'h00, 8'h00, 2, 0);
        for (k = 0; k < 4; k++) begin
            d = 8'($random(seed));
            wreg(8'h15 + 8'(k), d);
            rreg(8'h15 + 8'(k));
        end
        cyc(1, 1, 0, 8'h16, 8'h5a, 0, {8'h00, cfg[1]});
        cfg[1] = 8'h5a;
        rreg(8'h16);
        wreg(8'h17, 8'h20);
        cyc(0, 0, 1, 8'h00, 8'h00, 2, 1);
        for (k = 0; k < 64; k++) begin
            r = 16'($random(seed) | $random(seed));
            d = 8'($random(seed));
            wreg(8'h16, d);
            wreg(8'h17, {d[7:6], 1'(k >> 4), 3'(k), d[1:0]});
            pg = k[3] ? 8'hff : r[7:0];
            pg_sh = k[3] | r[8];
            pg_b = k[3] | r[9];
            pins = r[15:10];
            cyc(0, 0, 1, 8'h00, 8'h00, 1, {15'h0, f_exp()});
            cyc(0, 0, 1, 8'h00, 8'h00, 2, {15'h0, cfg[2][5]});
        end
        for (k = 0; k < 8; k++) begin
            wreg(8'h15, {2'b00, 3'(7 - k), 3'(k)});
            cyc(0, 0, 0, 8'h00, 8'h00, 0, 0);
            cond = 1'b1;
            notes.push_back({2'd3, 16'(MS_TAB[k] * MS)});
            wait_e(1'b1);
            cond = 1'b0;
            notes.push_back({2'd3, 16'(MS_TAB[7 - k] * MS)});
            wait_e(1'b0);
        end
        wreg(8'h15, 8'h02);
        cyc(0, 0, 0, 8'h00, 8'h00, 0, 0);
        cond = 1'b1;
        repeat (3) @(negedge clk);
        cond = 1'b0;
        repeat (30) @(negedge clk);
        wreg(8'h15, 8'h10);
        cond = 1'b1;
        notes.push_back({2'd3, 16'h0000});
        wait_e(1'b1);
        cond = 1'b0;
        repeat (3) @(negedge clk);
        cond = 1'b1;
        repeat (30) @(negedge clk);
        cond = 1'b0;
        notes.push_back({2'd3, 16'(MS_TAB[2] * MS)});
        wait_e(1'b0);
        final_report();
    end
endmodule
`default_nettype wire
